// [gmc_pkg.sv]
// Purpose: constants for the gauge operating-mode controller
// Assumes: 100 MHz clk, APB register access, 32-bit data
// Notes: long counts become top-level parameters
// Contract
// - With pin detection on, a falling present pin means battery inserted.
// - With pin detection on, a rising present pin means battery removed.
// - With pin detection off, presence comes only from insert and remove commands.
// - Normal mode only after insertion detected and initialization finished. Code: a removal in sleep also leads back to normal.
// - Termination: low current 80 s, capacity change, voltage above charge minus 100 mV.
// - On termination clear charging flag; fill remaining from full if enabled.
// - Power-up reset leads into initialization mode.
// - Reset copies default configuration into working registers before initialization.
// - Power-on reset or reset command sets the defaults-restored flag.
// - Insertion starts voltage measurement and clears the learned bits.
// - Halted initialization still serves host commands then halts again.
// - Enter-config command sets config flag and suspends gauging. Code: from init and normal only; in sleep it just returns to normal.
// - Resume command clears defaults-restored and config flags, resumes gauging.
// - Config mode exits on its own after about 240 s.
// - Normal mode measures and refreshes once per second.
// - Sleep only if sleep allowed and average current below sleep threshold.
// - Calibrate the converter after sleep qualifies, before entering sleep.
// - Sleep gates the fast oscillator yet still measures periodically.
// - Leave sleep once any entry condition fails.
// - Hibernate on request after valid voltage reading and low current, or low voltage.
// - Stay in hibernate until addressed bus traffic; other traffic wakes briefly.
// - Pin detection enable is bit 5 of the operation configuration high byte.
package gmc_pkg;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_MEAS = 8'h08;
  localparam logic [7:0] ADDR_THR = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CAP = 8'h14;
  localparam logic [15:0] CONFIG_DEFAULT = 16'h89F8;
  localparam int CFG_PIN_DET = 13;
  localparam int CFG_SLEEP = 5;
  localparam int CFG_FILL = 4;
  localparam logic [7:0] CMD_INSERT = 8'h0C;
  localparam logic [7:0] CMD_REMOVE = 8'h0D;
  localparam logic [7:0] CMD_ENTER_CFG = 8'h13;
  localparam logic [7:0] CMD_RESUME = 8'h42;
  localparam logic [7:0] CMD_RESET = 8'h41;
  localparam logic [7:0] CMD_HIB_REQ = 8'h11;
  localparam logic [15:0] TAPER_DEFAULT = 16'd75;
  localparam logic [15:0] SLEEP_CUR_DEFAULT = 16'd10;
  localparam logic [15:0] TERM_MARGIN_MV = 16'd100;
  localparam int CLK_HZ = 100000000;
  localparam int DEB_NS = 1000;
  localparam int DEB_CYC = (DEB_NS + 9) / 10;
  localparam int TICK_S = 1;
  localparam int TERM_S = 80;
  localparam int CFG_TO_S = 240;
  localparam int CAL_CYC = 16;
  localparam int INIT_CYC = 32;
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_NORMAL = 3'b001,
    ST_CONFIG = 3'b010,
    ST_CAL = 3'b011,
    ST_SLEEP = 3'b100,
    ST_HIB = 3'b101,
    ST_WAKE = 3'b110
  } gmc_state_t;
endpackage

// [gmc_mode_ctrl.sv]
// Purpose: operating-mode controller of a battery gauge
// Assumes: host writes measurements and commands over APB
// Notes: seconds tick is a parameter so tests can shorten it
module gmc_mode_ctrl import gmc_pkg::*; #(
  parameter int TICK_CYC = CLK_HZ * TICK_S
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic batteryPresentPin,
  input wire logic busAddressed,
  input wire logic busOther,
  output logic hfOscEn,
  output logic measStrobe,
  output logic calStart,
  output logic voltMeasStart,
  output logic [2:0] mode
);
  gmc_state_t state_r;
  logic [15:0] config_r;
  logic [15:0] avgCur_r, volt_r, chgVolt_r, taper_r, sleepCur_r, hibCur_r, hibVolt_r;
  logic [15:0] remCap_r, fullCap_r;
  logic capGain_r;
  logic defaultsRestored_r, configFlag_r, charging_r, capLearned_r, resLearned_r;
  logic hibReq_r, voltageTaken_r, present_r, initDone_r;
  logic pinS1_r, pinS2_r, pinDeb_r, pinPrev_r;
  logic [7:0] debCnt_r;
  logic [31:0] tickCnt_r;
  logic tick_r;
  logic [7:0] secCnt_r;
  logic [7:0] termCnt_r;
  logic [7:0] cfgCnt_r;
  logic [5:0] stepCnt_r;
  logic wr, rd;
  logic cmdValid;
  logic [7:0] cmdCode;
  logic insertEv, removeEv, termEv;

  function automatic logic below(input logic [15:0] a, input logic [15:0] b);
    below = a < b;
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign cmdValid = wr && (paddr == ADDR_CMD);
  assign cmdCode = pwdata[7:0];

  // Two-stage sync, then debounce on the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_r <= 1'b1;
      pinS2_r <= 1'b1;
    end else begin
      pinS1_r <= batteryPresentPin;
      pinS2_r <= pinS1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debCnt_r <= 8'h00;
      pinDeb_r <= 1'b1;
      pinPrev_r <= 1'b1;
    end else begin
      pinPrev_r <= pinDeb_r;
      if (pinS2_r == pinDeb_r) begin
        debCnt_r <= 8'h00;
      end else if (debCnt_r == 8'(DEB_CYC - 1)) begin
        debCnt_r <= 8'h00;
        pinDeb_r <= pinS2_r;
      end else begin
        debCnt_r <= debCnt_r + 8'h01;
      end
    end
  end

  always_comb begin
    insertEv = 1'b0;
    removeEv = 1'b0;
    if (config_r[CFG_PIN_DET]) begin
      insertEv = pinPrev_r && !pinDeb_r;
      removeEv = !pinPrev_r && pinDeb_r;
    end else begin
      insertEv = cmdValid && (cmdCode == CMD_INSERT);
      removeEv = cmdValid && (cmdCode == CMD_REMOVE);
    end
  end

  // One-second cadence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (tickCnt_r == 32'(TICK_CYC - 1)) begin
      tickCnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // Termination window: 80 ticks of low current, voltage near full checked on the last tick only
  assign termEv = tick_r && (state_r == ST_NORMAL) && charging_r && (termCnt_r == 8'(TERM_S - 1)) &&
    below(avgCur_r, taper_r) && capGain_r && (volt_r > chgVolt_r - TERM_MARGIN_MV);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      termCnt_r <= 8'h00;
    end else if (tick_r) begin
      if (state_r != ST_NORMAL || !below(avgCur_r, taper_r) || termEv) begin
        termCnt_r <= 8'h00;
      end else if (termCnt_r != 8'(TERM_S - 1)) begin
        termCnt_r <= termCnt_r + 8'h01;
      end
    end
  end

  // Registers; reset loads defaults from constants
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_r <= CONFIG_DEFAULT;
      avgCur_r <= 16'h0000;
      volt_r <= 16'h0000;
      chgVolt_r <= 16'hFFFF;
      taper_r <= TAPER_DEFAULT;
      sleepCur_r <= SLEEP_CUR_DEFAULT;
      hibCur_r <= 16'h0000;
      hibVolt_r <= 16'h0000;
      capGain_r <= 1'b0;
      fullCap_r <= 16'h0000;
    end else if (wr) begin
      case (paddr)
        ADDR_CONFIG: if (state_r == ST_CONFIG) config_r <= pwdata[15:0];
        ADDR_MEAS: begin
          avgCur_r <= pwdata[15:0];
          volt_r <= pwdata[31:16];
        end
        ADDR_THR: begin
          if (state_r == ST_CONFIG) begin
            taper_r <= pwdata[15:0];
            sleepCur_r <= pwdata[31:16];
          end
        end
        ADDR_CAP: begin
          fullCap_r <= pwdata[15:0];
          chgVolt_r <= pwdata[31:16];
        end
        ADDR_STATUS: begin
          hibCur_r <= pwdata[15:0];
          hibVolt_r <= pwdata[31:16];
          capGain_r <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remCap_r <= 16'h0000;
    end else if (termEv && config_r[CFG_FILL]) begin
      remCap_r <= fullCap_r;
    end
  end

  // Main mode machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_INIT;
      defaultsRestored_r <= 1'b1;
      configFlag_r <= 1'b0;
      charging_r <= 1'b1;
      capLearned_r <= 1'b1;
      resLearned_r <= 1'b1;
      hibReq_r <= 1'b0;
      voltageTaken_r <= 1'b0;
      present_r <= 1'b0;
      initDone_r <= 1'b0;
      stepCnt_r <= 6'h00;
      cfgCnt_r <= 8'h00;
      voltMeasStart <= 1'b0;
      calStart <= 1'b0;
    end else begin
      voltMeasStart <= 1'b0;
      calStart <= 1'b0;
      if (termEv) charging_r <= 1'b0;
      if (cmdValid && cmdCode == CMD_HIB_REQ) hibReq_r <= 1'b1;
      if (cmdValid && cmdCode == CMD_RESET) defaultsRestored_r <= 1'b1;
      if (removeEv) begin
        present_r <= 1'b0;
        initDone_r <= 1'b0;
      end
      if (insertEv) begin
        present_r <= 1'b1;
        initDone_r <= 1'b0;
        stepCnt_r <= 6'h00;
        voltMeasStart <= 1'b1;
        capLearned_r <= 1'b0;
        resLearned_r <= 1'b0;
        voltageTaken_r <= 1'b1;
      end
      case (state_r)
        ST_INIT: begin
          // Commands are served through the bus while halted
          if (present_r && !initDone_r) begin
            if (stepCnt_r == 6'(INIT_CYC - 1)) initDone_r <= 1'b1;
            else stepCnt_r <= stepCnt_r + 6'h01;
          end
          if (cmdValid && cmdCode == CMD_ENTER_CFG) begin
            state_r <= ST_CONFIG;
            configFlag_r <= 1'b1;
            cfgCnt_r <= 8'h00;
          end else if (present_r && initDone_r && !removeEv) begin
            state_r <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (removeEv) begin
            state_r <= ST_INIT;
          end else if (cmdValid && cmdCode == CMD_ENTER_CFG) begin
            state_r <= ST_CONFIG;
            configFlag_r <= 1'b1;
            cfgCnt_r <= 8'h00;
          end else if (tick_r && hibReq_r && voltageTaken_r &&
                       (below(avgCur_r, hibCur_r) || below(volt_r, hibVolt_r))) begin
            state_r <= ST_HIB;
          end else if (tick_r && config_r[CFG_SLEEP] && below(avgCur_r, sleepCur_r)) begin
            state_r <= ST_CAL;
            calStart <= 1'b1;
            stepCnt_r <= 6'h00;
          end
        end
        ST_CONFIG: begin
          if (tick_r) cfgCnt_r <= cfgCnt_r + 8'h01;
          if (cmdValid && cmdCode == CMD_RESUME) begin
            state_r <= ST_INIT;
            configFlag_r <= 1'b0;
            defaultsRestored_r <= 1'b0;
          end else if (tick_r && cfgCnt_r == 8'(CFG_TO_S - 1)) begin
            state_r <= ST_INIT;
            configFlag_r <= 1'b0;
          end
        end
        ST_CAL: begin
          if (stepCnt_r == 6'(CAL_CYC - 1)) state_r <= ST_SLEEP;
          else stepCnt_r <= stepCnt_r + 6'h01;
        end
        ST_SLEEP: begin
          if (!config_r[CFG_SLEEP] || !below(avgCur_r, sleepCur_r) || removeEv ||
              (cmdValid && cmdCode == CMD_ENTER_CFG)) begin
            state_r <= ST_NORMAL;
          end
        end
        ST_HIB: begin
          if (busAddressed) begin
            state_r <= ST_INIT;
            // A fresh request in the same cycle wins over the wake clear
            if (!(cmdValid && cmdCode == CMD_HIB_REQ)) hibReq_r <= 1'b0;
            initDone_r <= 1'b0;
            stepCnt_r <= 6'h00;
          end else if (busOther) begin
            state_r <= ST_WAKE;
          end
        end
        ST_WAKE: state_r <= ST_HIB;
        default: state_r <= ST_INIT;
      endcase
    end
  end

  // Outputs all from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hfOscEn <= 1'b1;
      measStrobe <= 1'b0;
      mode <= 3'b000;
    end else begin
      hfOscEn <= !(state_r == ST_SLEEP || state_r == ST_HIB);
      measStrobe <= tick_r && (state_r == ST_NORMAL || state_r == ST_SLEEP);
      mode <= state_r;
    end
  end

  // APB: zero-wait answer, unmapped reads as zero with error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > ADDR_CAP || paddr[1:0] != 2'b00);
      if (rd) begin
        case (paddr)
          ADDR_CONFIG: prdata <= {16'h0000, config_r};
          ADDR_MEAS: prdata <= {volt_r, avgCur_r};
          ADDR_THR: prdata <= {sleepCur_r, taper_r};
          ADDR_STATUS: prdata <= {20'h00000, 1'b0, state_r, voltageTaken_r, hibReq_r, resLearned_r, capLearned_r,
                                  charging_r, configFlag_r, defaultsRestored_r, present_r};
          ADDR_CAP: prdata <= {fullCap_r, remCap_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  property p_insert;
    @(posedge clk) disable iff (!rst_n) (config_r[CFG_PIN_DET] && pinPrev_r && !pinDeb_r) |=> present_r;
  endproperty
  a_insert: assert property (p_insert) else $error("insert not taken");
  property p_remove;
    @(posedge clk) disable iff (!rst_n) (config_r[CFG_PIN_DET] && !pinPrev_r && pinDeb_r) |=> !present_r;
  endproperty
  a_remove: assert property (p_remove) else $error("remove not taken");
  property p_cmd_only;
    @(posedge clk) disable iff (!rst_n) (!config_r[CFG_PIN_DET] && !cmdValid) |=> present_r == $past(present_r);
  endproperty
  a_cmd_only: assert property (p_cmd_only) else $error("presence changed without command");
  property p_normal;
    @(posedge clk) disable iff (!rst_n) ($past(state_r) == ST_INIT && state_r == ST_NORMAL) |-> $past(initDone_r);
  endproperty
  a_normal: assert property (p_normal) else $error("normal without init");
  property p_cfg;
    @(posedge clk) disable iff (!rst_n) (state_r == ST_NORMAL && cmdValid && cmdCode == CMD_ENTER_CFG) |=>
      (state_r == ST_CONFIG && configFlag_r);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config entry failed");
  property p_resume;
    @(posedge clk) disable iff (!rst_n) (state_r == ST_CONFIG && cmdValid && cmdCode == CMD_RESUME) |=>
      (!configFlag_r && !defaultsRestored_r);
  endproperty
  a_resume: assert property (p_resume) else $error("resume failed");
  // Run length of the calibration state, for checking only
  logic [4:0] calLen_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calLen_r <= 5'h00;
    end else if (state_r == ST_CAL) begin
      calLen_r <= calLen_r + 5'h01;
    end else begin
      calLen_r <= 5'h00;
    end
  end
  sequence s_cal_end;
    state_r == ST_CAL && calLen_r == 5'(CAL_CYC - 1);
  endsequence
  property p_cal;
    @(posedge clk) disable iff (!rst_n) s_cal_end |=> state_r == ST_SLEEP;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration length wrong");
  property p_cal_len;
    @(posedge clk) disable iff (!rst_n) (state_r == ST_CAL) |-> calLen_r < 5'(CAL_CYC);
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration overran");
  property p_term;
    @(posedge clk) disable iff (!rst_n) (termEv && config_r[CFG_FILL]) |=>
      (!charging_r && remCap_r == $past(fullCap_r));
  endproperty
  a_term: assert property (p_term) else $error("termination not applied");
  property p_cfg_to;
    @(posedge clk) disable iff (!rst_n) (state_r == ST_CONFIG && tick_r && cfgCnt_r == 8'(CFG_TO_S - 1)) |=>
      (state_r == ST_INIT && !configFlag_r);
  endproperty
  a_cfg_to: assert property (p_cfg_to) else $error("config timeout missed");
  property p_osc;
    @(posedge clk) disable iff (!rst_n) (state_r == ST_SLEEP) |=> !hfOscEn;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator on in sleep");
  property p_wake;
    @(posedge clk) disable iff (!rst_n) (state_r == ST_WAKE) |=> state_r == ST_HIB;
  endproperty
  a_wake: assert property (p_wake) else $error("brief wake stuck");
endmodule

// [gmc_host_model.sv]
// Purpose: far-side model of the pack, present pin and management bus
// Assumes: pack pulls the pin low, weak pull-up otherwise
// Notes: bus activity is a one-cycle pulse after a request
module gmc_host_model (
  input wire logic clk,
  input wire logic packIn,
  input wire logic reqAddr,
  input wire logic reqOther,
  output logic batteryPresentPin,
  output logic busAddressed,
  output logic busOther
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins when the pack is gone, so the pin never floats
  assign batteryPresentPin = packIn ? 1'b0 : 1'b1;
  // Pulses settle low on the first edge, while the block is still in reset
  always_ff @(posedge clk) begin
    busAddressed <= reqAddr;
    busOther <= reqOther;
  end
endmodule

// [tb_top.sv]
// Purpose: self-checking bench of the gauge mode controller
// Assumes: zero-wait APB slave, short seconds tick
// Notes: runs as one sequence, each scenario leaves the next its state
module tb_top;
  import gmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 100;
  logic clk, rst_n, psel, penable, pwrite, packIn, reqA, reqO;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, pin, busA, busO, hfOscEn, measStrobe, calStart, voltMeasStart;
  logic [2:0] mode;
  int err_count, checks, measCnt, calCnt, vmCnt, n;
  gmc_mode_ctrl #(.TICK_CYC(TK)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .batteryPresentPin(pin), .busAddressed(busA), .busOther(busO), .hfOscEn(hfOscEn),
    .measStrobe(measStrobe), .calStart(calStart), .voltMeasStart(voltMeasStart), .mode(mode));
  gmc_host_model host_u (.clk(clk), .packIn(packIn), .reqAddr(reqA), .reqOther(reqO),
    .batteryPresentPin(pin), .busAddressed(busA), .busOther(busO));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (measStrobe === 1'b1) measCnt++;
    if (calStart === 1'b1) calCnt++;
    if (voltMeasStart === 1'b1) vmCnt++;
  end
  task automatic print_verdict;
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      chk({31'h0, pready}, 32'h1);
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    apb(1'b1, ADDR_CMD, {24'h0, c});
  endtask
  task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & mask, exp);
  endtask
  // Waits until mode equals m (eq=1) or differs from m (eq=0)
  task automatic waitMode(input logic [2:0] m, input bit eq, input int bound);
    int i;
    for (i = 0; i < bound && ((mode === m) != eq); i++) @(posedge clk);
    if ((mode === m) != eq) begin
      chk({29'h0, mode}, {29'h0, m});
      print_verdict();
    end
  endtask
  task automatic t_reset;
    chk({31'h0, hfOscEn}, 32'h1);
    chk({29'h0, mode}, {29'h0, ST_INIT});
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, {16'h0, CONFIG_DEFAULT});
    stat(32'h3, 32'h2);
  endtask
  task automatic t_insert;
    // Current above the sleep threshold keeps normal mode steady
    apb(1'b1, ADDR_MEAS, {16'd4150, 16'd50});
    packIn <= 1'b1;
    repeat (300) @(posedge clk);
    stat(32'h701, 32'h0);
    cmd(CMD_INSERT);
    waitMode(ST_NORMAL, 1, 300);
    chk(vmCnt, 1);
    // Insertion clears both learned bits and flags the voltage reading
    stat(32'hB1, 32'h81);
  endtask
  task automatic t_config;
    cmd(CMD_ENTER_CFG);
    waitMode(ST_CONFIG, 1, 50);
    stat(32'h4, 32'h4);
    // Sampled only once a late strobe from normal mode has been counted
    n = measCnt;
    repeat (300) @(posedge clk);
    chk(measCnt, n);
    apb(1'b1, ADDR_CONFIG, {16'h0, CONFIG_DEFAULT | 16'h2000});
    apb(1'b1, ADDR_THR, {SLEEP_CUR_DEFAULT, TAPER_DEFAULT});
    apb(1'b1, ADDR_CAP, {16'd4200, 16'd1000});
    cmd(CMD_RESUME);
    waitMode(ST_NORMAL, 1, 300);
    stat(32'h6, 32'h0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, 32'hA9F8);
  endtask
  task automatic t_pin;
    n = vmCnt;
    packIn <= 1'b0;
    repeat (50) @(posedge clk);
    stat(32'h1, 32'h1);
    repeat (150) @(posedge clk);
    stat(32'h1, 32'h0);
    packIn <= 1'b1;
    repeat (200) @(posedge clk);
    stat(32'h1, 32'h1);
    chk(vmCnt, n + 1);
    waitMode(ST_NORMAL, 1, 300);
  endtask
  task automatic t_tick;
    n = measCnt;
    repeat (10 * TK) @(posedge clk);
    chk({31'h0, (measCnt - n) >= 9 && (measCnt - n) <= 11}, 32'h1);
  endtask
  task automatic t_term;
    apb(1'b1, ADDR_MEAS, {16'd4150, 16'd50});
    apb(1'b1, ADDR_STATUS, 32'h0);
    repeat (85 * TK) @(posedge clk);
    apb(1'b0, ADDR_CAP, 32'h0);
    chk(rd, {16'd1000, 16'd1000});
    stat(32'h8, 32'h0);
  endtask
  task automatic t_sleep;
    n = calCnt;
    apb(1'b1, ADDR_MEAS, {16'd4150, 16'd5});
    waitMode(ST_CAL, 1, 3 * TK);
    chk(calCnt, n + 1);
    waitMode(ST_SLEEP, 1, 100);
    chk({31'h0, hfOscEn}, 32'h0);
    n = measCnt;
    repeat (3 * TK) @(posedge clk);
    chk({31'h0, measCnt > n}, 32'h1);
    apb(1'b1, ADDR_MEAS, {16'd4150, 16'd20});
    waitMode(ST_NORMAL, 1, 3 * TK);
    chk({31'h0, hfOscEn}, 32'h1);
  endtask
  task automatic t_timeout;
    cmd(CMD_ENTER_CFG);
    waitMode(ST_CONFIG, 1, 50);
    repeat (230 * TK) @(posedge clk);
    chk({29'h0, mode}, {29'h0, ST_CONFIG});
    waitMode(ST_CONFIG, 0, 20 * TK);
    stat(32'h4, 32'h0);
    waitMode(ST_NORMAL, 1, 300);
  endtask
  task automatic t_misc;
    apb(1'b1, ADDR_CONFIG, 32'h0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, 32'hA9F8);
    cmd(CMD_RESET);
    stat(32'h2, 32'h2);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_hib;
    apb(1'b1, ADDR_STATUS, {16'd3000, 16'd30});
    cmd(CMD_HIB_REQ);
    stat(32'h40, 32'h40);
    waitMode(ST_HIB, 1, 3 * TK);
    chk({31'h0, hfOscEn}, 32'h0);
    reqO <= 1'b1;
    @(posedge clk);
    reqO <= 1'b0;
    repeat (30) @(posedge clk);
    chk({29'h0, mode}, {29'h0, ST_HIB});
    reqA <= 1'b1;
    @(posedge clk);
    reqA <= 1'b0;
    waitMode(ST_HIB, 0, 50);
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    packIn = 1'b0;
    reqA = 1'b0;
    reqO = 1'b0;
    err_count = 0;
    checks = 0;
    measCnt = 0;
    calCnt = 0;
    vmCnt = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_insert();
    t_config();
    t_pin();
    t_tick();
    t_term();
    t_sleep();
    t_timeout();
    t_misc();
    t_hib();
    print_verdict();
  end
endmodule
